// [rtl/asfa_defines.vh]
// Purpose: Constants for the add/subtract flag unit and its AHB-Lite register map
// Assumes: 32-bit word registers at aligned byte offsets
// Notes: Included by bare name from the ALU design file only; the adder does not include it
`ifndef ASFA_DEFINES_VH
`define ASFA_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ASFA_OFS_CMD 8'h00
`define ASFA_OFS_IMM 8'h04
`define ASFA_OFS_FLAGS 8'h08
`define ASFA_OFS_STATUS 8'h0C
`define ASFA_OFS_RESULT 8'h10
`define ASFA_OFS_GPR_BASE 8'h40

// ---------------------------------------------------------------
// Command word field positions
// ---------------------------------------------------------------
`define ASFA_CMD_OP_LSB 0
`define ASFA_CMD_OP_MSB 2
`define ASFA_CMD_USE_IMM 3
`define ASFA_CMD_DST_OMIT 4
`define ASFA_CMD_DST_LSB 8
`define ASFA_CMD_DST_MSB 11
`define ASFA_CMD_SRC1_LSB 12
`define ASFA_CMD_SRC1_MSB 15
`define ASFA_CMD_SRC2_LSB 16
`define ASFA_CMD_SRC2_MSB 19

// ---------------------------------------------------------------
// Operation codes
// ---------------------------------------------------------------
`define ASFA_OP_ADD 3'h0
`define ASFA_OP_ADDS 3'h1
`define ASFA_OP_ADD_WITH_CARRY 3'h2
`define ASFA_OP_SUB 3'h3
`define ASFA_OP_SUBTRACT_SET_FLAGS 3'h4
`define ASFA_OP_SUBTRACT_WITH_CARRY 3'h5
`define ASFA_OP_NEGATE_FROM_ZERO 3'h6

// ---------------------------------------------------------------
// Flag bit positions, register numbers, immediate limits
// ---------------------------------------------------------------
`define ASFA_FLAG_V 0
`define ASFA_FLAG_C 1
`define ASFA_FLAG_Z 2
`define ASFA_FLAG_N 3
`define ASFA_ST_DONE 0
`define ASFA_ST_ILLEGAL 1
`define ASFA_REG_SP 4'hD
`define ASFA_REG_PC 4'hF
`define ASFA_IMM_W 10
`define ASFA_IMM_SP_MAX 10'h1FC
`define ASFA_IMM_PTR_MAX 10'h3FC
`define ASFA_IMM_SMALL_MAX 10'h007
`define ASFA_IMM_BYTE_MAX 10'h0FF

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define ASFA_RST_WORD 32'h0000_0000
`define ASFA_RST_FLAGS 4'h0
`define ASFA_RST_IMM 10'h000

`endif

// [rtl/asfa_adder.v]
// Purpose: 32-bit adder with carry in, carry out and signed overflow
// Assumes: Subtraction is formed by the caller inverting b and choosing cin
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none

module asfa_adder
(
	input wire [31:0] a_i,
	input wire [31:0] b_i,
	input wire cin_i,
	output wire [31:0] sum_o,
	output wire carry_o,
	output wire ovf_o
);

	wire [32:0] total;

	assign total = {1'b0, a_i} + {1'b0, b_i} + {32'h0000_0000, cin_i};
	assign sum_o = total[31:0];
	assign carry_o = total[32];
	// Signed overflow: like-signed inputs giving an unlike-signed sum
	assign ovf_o = (a_i[31] == b_i[31]) && (total[31] != a_i[31]);

endmodule // asfa_adder

`default_nettype wire

// [rtl/asfa_alu.v]
// Purpose: Add/subtract execution unit with condition flags, AHB-Lite register slave
// Assumes: Single word transfers; the slave always answers OKAY
// Notes: A write to the command register runs one operation in the next cycle
//
// Overview of operation
// - Add-with-carry sums both sources plus one if carry is set, writes the destination, updates all flags.
// - Plain add writes first source plus second register or immediate, flags unchanged.
// - Flag-setting add gives the plain add result and updates N, Z, C and V from it.
// - Negate-from-zero subtracts the first source from zero, writes it and updates all flags.
// - Subtract-with-carry takes second from first, one more when carry is set, and updates all flags.
// - Plain subtract takes the second register or immediate from the first, flags unchanged.
// - Flag-setting subtract gives the plain subtract result and updates all four flags.
// - An omitted destination means the destination is the first source register.
// - Stack pointer adjust takes 0 to 508, pointer-relative add 0 to 1020, both multiples of four.
// - Flag-setting immediate forms take 0 to 7, or 0 to 255 only when destination equals first source.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "asfa_defines.vh"

module asfa_alu
(
	input wire clk_i,
	input wire rst_b_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	output reg [31:0] hrdata_o,
	output wire hreadyout_o,
	output wire hresp_o,
	output wire [3:0] flags_o
);

	// ---------------------------------------------------------------
	// Legality of an operand combination
	// ---------------------------------------------------------------
	function legal_fn;
		input [2:0] op;
		input use_imm;
		input [3:0] dst;
		input [3:0] src1;
		input [3:0] src2;
		input [9:0] imm;
		reg low3;
		reg mult4;
		begin
			low3 = !dst[3] && !src1[3] && (use_imm || !src2[3]);
			mult4 = (imm[1:0] == 2'b00);
			case (op)
				`ASFA_OP_ADD:
					if (use_imm)
						legal_fn = (dst == `ASFA_REG_SP && src1 == `ASFA_REG_SP && mult4
							&& imm <= `ASFA_IMM_SP_MAX)
							|| (!dst[3] && (src1 == `ASFA_REG_SP || src1 == `ASFA_REG_PC)
							&& mult4 && imm <= `ASFA_IMM_PTR_MAX);
					else
						legal_fn = !(src1 == `ASFA_REG_PC && src2 == `ASFA_REG_PC);
				`ASFA_OP_SUB:
					if (use_imm)
						legal_fn = dst == `ASFA_REG_SP && src1 == `ASFA_REG_SP && mult4
							&& imm <= `ASFA_IMM_SP_MAX;
					else
						legal_fn = low3;
				`ASFA_OP_ADDS, `ASFA_OP_SUBTRACT_SET_FLAGS:
					legal_fn = low3 && (!use_imm || imm <= `ASFA_IMM_SMALL_MAX
						|| (dst == src1 && imm <= `ASFA_IMM_BYTE_MAX));
				`ASFA_OP_ADD_WITH_CARRY, `ASFA_OP_SUBTRACT_WITH_CARRY:
					legal_fn = low3 && !use_imm && dst == src1;
				`ASFA_OP_NEGATE_FROM_ZERO:
					legal_fn = low3 && !use_imm;
				default:
					legal_fn = 1'b0;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	reg [31:0] gpr_r [0:15];
	reg [19:0] cmd_r;
	reg [9:0] imm_r;
	reg [3:0] flags_r;
	reg [31:0] result_r;
	reg done_r;
	reg illegal_r;
	reg pend_r;
	reg [7:0] daddr_r;
	reg dwrite_r;
	reg dact_r;

	// ---------------------------------------------------------------
	// AHB-Lite address phase
	// ---------------------------------------------------------------
	wire addr_take;

	// Register stall is one cycle while a command executes, so bus
	// writes never meet the execution write port in the same cycle
	assign hreadyout_o = !pend_r;
	assign hresp_o = 1'b0;
	assign flags_o = flags_r;
	assign addr_take = hsel_i && htrans_i[1] && hready_i;

	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			dact_r <= 1'b0;
			dwrite_r <= 1'b0;
			daddr_r <= 8'h00;
		end
		else if (hready_i)
		begin
			dact_r <= addr_take;
			dwrite_r <= hwrite_i;
			daddr_r <= haddr_i[7:0];
		end
	end

	// ---------------------------------------------------------------
	// Operand selection and execution
	// ---------------------------------------------------------------
	wire [2:0] op;
	wire use_imm;
	wire [3:0] src1;
	wire [3:0] src2;
	wire [3:0] dst;
	wire is_sub;
	wire sets_flags;
	wire ok;
	reg [31:0] add_a;
	reg [31:0] add_b;
	reg add_cin;
	wire [31:0] sum;
	wire sum_c;
	wire sum_v;
	wire [31:0] opnd_b;

	assign op = cmd_r[`ASFA_CMD_OP_MSB:`ASFA_CMD_OP_LSB];
	assign use_imm = cmd_r[`ASFA_CMD_USE_IMM];
	assign src1 = cmd_r[`ASFA_CMD_SRC1_MSB:`ASFA_CMD_SRC1_LSB];
	assign src2 = cmd_r[`ASFA_CMD_SRC2_MSB:`ASFA_CMD_SRC2_LSB];
	assign dst = cmd_r[`ASFA_CMD_DST_OMIT] ? src1
		: cmd_r[`ASFA_CMD_DST_MSB:`ASFA_CMD_DST_LSB];
	assign opnd_b = use_imm ? {22'h00_0000, imm_r} : gpr_r[src2];
	assign is_sub = (op == `ASFA_OP_SUB) || (op == `ASFA_OP_SUBTRACT_SET_FLAGS) || (op == `ASFA_OP_SUBTRACT_WITH_CARRY);
	assign sets_flags = (op != `ASFA_OP_ADD) && (op != `ASFA_OP_SUB);
	assign ok = legal_fn(op, use_imm, dst, src1, src2, imm_r);

	always @*
	begin
		add_a = gpr_r[src1];
		add_b = is_sub ? ~opnd_b : opnd_b;
		add_cin = is_sub;
		case (op)
			`ASFA_OP_ADD_WITH_CARRY:
				add_cin = flags_r[`ASFA_FLAG_C];
			`ASFA_OP_SUBTRACT_WITH_CARRY:
				add_cin = !flags_r[`ASFA_FLAG_C];
			`ASFA_OP_NEGATE_FROM_ZERO:
			begin
				add_a = `ASFA_RST_WORD;
				add_b = ~gpr_r[src1];
				add_cin = 1'b1;
			end
			default:
				add_cin = is_sub;
		endcase
	end

	asfa_adder u_adder
	(
		.a_i(add_a),
		.b_i(add_b),
		.cin_i(add_cin),
		.sum_o(sum),
		.carry_o(sum_c),
		.ovf_o(sum_v)
	);

	// ---------------------------------------------------------------
	// Data phase writes and execution
	// ---------------------------------------------------------------
	wire bus_wr;
	integer i;

	assign bus_wr = dact_r && dwrite_r && !pend_r;

	always @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			for (i = 0; i < 16; i = i + 1)
				gpr_r[i] <= `ASFA_RST_WORD;
			cmd_r <= 20'h0_0000;
			imm_r <= `ASFA_RST_IMM;
			flags_r <= `ASFA_RST_FLAGS;
			result_r <= `ASFA_RST_WORD;
			done_r <= 1'b0;
			illegal_r <= 1'b0;
			pend_r <= 1'b0;
		end
		else if (pend_r)
		begin
			pend_r <= 1'b0;
			done_r <= 1'b1;
			illegal_r <= !ok;
			if (ok)
			begin
				gpr_r[dst] <= sum;
				result_r <= sum;
				if (sets_flags)
					flags_r <= {sum[31], sum == 32'h0000_0000, sum_c, sum_v};
			end
		end
		else if (bus_wr)
		begin
			case (daddr_r)
				`ASFA_OFS_CMD:
				begin
					cmd_r <= hwdata_i[19:0];
					pend_r <= 1'b1;
					done_r <= 1'b0;
					illegal_r <= 1'b0;
				end
				`ASFA_OFS_IMM:
					imm_r <= hwdata_i[`ASFA_IMM_W-1:0];
				`ASFA_OFS_FLAGS:
					flags_r <= hwdata_i[3:0];
				default:
					if (daddr_r[7:6] == 2'b01)
						gpr_r[daddr_r[5:2]] <= hwdata_i;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Selected from flip-flops by the held address, so a read that
	// follows a command sees the executed result after the stall
	always @*
	begin
		hrdata_o = 32'h0000_0000;
		if (dact_r && !dwrite_r)
		begin
			case (daddr_r)
				`ASFA_OFS_CMD:
					hrdata_o = {12'h000, cmd_r};
				`ASFA_OFS_IMM:
					hrdata_o = {22'h00_0000, imm_r};
				`ASFA_OFS_FLAGS:
					hrdata_o = {28'h000_0000, flags_r};
				`ASFA_OFS_STATUS:
					hrdata_o = {29'h0000_0000, pend_r, illegal_r, done_r};
				`ASFA_OFS_RESULT:
					hrdata_o = result_r;
				default:
					if (daddr_r[7:6] == 2'b01)
						hrdata_o = gpr_r[daddr_r[5:2]];
			endcase
		end
	end

endmodule // asfa_alu

`default_nettype wire

// [tb/asfa_alu_sva.sv]
// Purpose: Bus and flag timing checks for asfa_alu
// Assumes: One master, hready_i fed from hreadyout_o
// Notes: Bound after the module
`timescale 1ns/1ps
`default_nettype none
module asfa_alu_chk
(
	input wire clk_i,
	input wire rst_b_i,
	input wire hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire [31:0] hwdata_i,
	input wire hready_i,
	input wire [31:0] hrdata_o,
	input wire hreadyout_o,
	input wire hresp_o,
	input wire [3:0] flags_o
);
logic rd_r;
logic cmd_r;
logic flw_r;
wire tk = hsel_i && htrans_i[1] && hready_i;
// Data phase markers hold through a stalled data phase
always @(posedge clk_i)
begin
	if (!rst_b_i || hready_i)
	begin
		rd_r <= rst_b_i && tk && !hwrite_i;
		cmd_r <= rst_b_i && tk && hwrite_i && haddr_i[7:0] == 8'h00;
		flw_r <= rst_b_i && tk && hwrite_i && haddr_i[7:0] == 8'h08;
	end
end
default clocking cb @(posedge clk_i);
endclocking
default disable iff (!rst_b_i);
sequence s_stall;
	!hreadyout_o ##1 hreadyout_o;
endsequence
okay_resp_a: assert property (hresp_o == 1'b0) else $error("bad response");
rst_out_a: assert property (disable iff (1'b0) !rst_b_i |=>
	flags_o == 4'h0 && hreadyout_o && hrdata_o == 32'h0) else $error("bad reset");
cmd_stall_a: assert property (cmd_r && hreadyout_o |=> s_stall) else $error("no stall");
stall_len_a: assert property (!hreadyout_o |=> hreadyout_o) else $error("long stall");
stall_cause_a: assert property ($fell(hreadyout_o) |-> $past(cmd_r)) else $error("odd stall");
rdata_idle_a: assert property (!rd_r |-> hrdata_o == 32'h0) else $error("bad rdata");
flag_src_a: assert property ($changed(flags_o) |->
	!$past(hreadyout_o) || $past(flw_r)) else $error("odd flags");
plain_flags_a: assert property (cmd_r && hreadyout_o &&
	hwdata_i[2:0] inside {3'h0, 3'h3, 3'h7} |=> ##1 $stable(flags_o)) else $error("flags moved");
endmodule // asfa_alu_chk
bind asfa_alu asfa_alu_chk i_asfa_alu_chk
(
	.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .flags_o(flags_o)
);
`default_nettype wire

// [tb/asfa_host.sv]
// Purpose: AHB-Lite master standing for the decoder side
// Assumes: Single word transfers, one slave
// Notes: Samples hready and read data at the rising edge, before that edge's updates land
`timescale 1ns/1ps
`default_nettype none
module asfa_host
(
	input wire logic clk_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output var logic hsel_o,
	output var logic [31:0] haddr_o,
	output var logic [1:0] htrans_o,
	output var logic hwrite_o,
	output var logic [2:0] hsize_o,
	output var logic [31:0] hwdata_o
);
initial {hsel_o, haddr_o, htrans_o, hwrite_o, hsize_o, hwdata_o} = {36'h0, 3'h2, 32'h0};
task automatic wt(output logic [31:0] q);
	@(posedge clk_i);
	while (hready_i !== 1'b1)
		@(posedge clk_i);
	q = hrdata_i;
endtask
task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
	output logic [31:0] q);
	hsel_o <= 1'b1;
	haddr_o <= a;
	hwrite_o <= w;
	htrans_o <= 2'h2;
	wt(q);
	hsel_o <= 1'b0;
	htrans_o <= 2'h0;
	hwdata_o <= d;
	wt(q);
	// Stale data must not look valid
	hwdata_o <= ~d;
endtask
endmodule // asfa_host
`default_nettype wire

// [tb/test_add_subtract_flag_alu.sv]
// Purpose: Self-checking bench for asfa_alu
// Assumes: Host model drives the bus
// Notes: Random operations from a fixed seed plus an operand-limit table
`timescale 1ns/1ps
`default_nettype none
module test_add_subtract_flag_alu;
logic clk_i = 1'b0;
logic rst_b_i = 1'b0;
logic [31:0] q;
logic [2:0] op;
logic [3:0] s1;
logic [3:0] dd;
int miscompares = 0;
int samples_checked = 0;
wire hsel, hwrite, hready, hresp;
wire [31:0] haddr, hwdata, hrdata;
wire [1:0] htrans;
wire [2:0] hsize;
wire [3:0] flags;
// Limit table entries: legal, immediate, command
// Registers that must read zero straight after a reset
logic [31:0] rz [6] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h74};
logic [42:0] lim [11] = '{{1'b1, 10'h1FC, 32'h0000DD08}, {1'b0, 10'h200, 32'h0000DD08},
	{1'b0, 10'h1FE, 32'h0000DD0B}, {1'b1, 10'h3FC, 32'h0000F108},
	{1'b1, 10'h007, 32'h00002109}, {1'b0, 10'h008, 32'h0000210C},
	{1'b1, 10'h0FF, 32'h00002519}, {1'b0, 10'h000, 32'h00032102},
	{1'b1, 10'h0F4, 32'h0000DD0B}, {1'b0, 10'h000, 32'h000FF100},
	{1'b0, 10'h000, 32'h00002107}};
asfa_alu i_asfa_alu
(
	.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
	.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
	.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .flags_o(flags)
);
asfa_host i_asfa_host
(
	.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
	.htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata)
);
initial
	forever #5 clk_i = ~clk_i;
initial
begin
	repeat (20000) @(posedge clk_i);
	miscompares++;
	test_done;
end
task chk(input logic [31:0] g, input logic [31:0] e);
	samples_checked++;
	if (g !== e)
	begin
		miscompares++;
		$display("BAD %0t got %h expected %h", $time, g, e);
	end
endtask
task test_done;
	$display("checked %0d mismatched %0d", samples_checked, miscompares);
	if (miscompares == 0 && samples_checked > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
task wr(input logic [31:0] a, input logic [31:0] d);
	i_asfa_host.xfer(a, 1'b1, d, q);
endtask
task rd(input logic [31:0] a);
	i_asfa_host.xfer(a, 1'b0, 32'h0, q);
endtask
task zero_chk;
	foreach (rz[k])
	begin
		rd(rz[k]);
		chk(q, 32'h0);
	end
endtask
function logic [31:0] pick(input int n);
	return (n == 0) ? 32'h0 : (n == 1) ? 32'h7FFFFFFF : (n == 2) ? 32'h80000000 : $urandom;
endfunction
// Returns {N, Z, C, V, result}; carry-in on subtract-with-carry follows the set-carry reading
function logic [35:0] calc(input logic [2:0] o, input logic [31:0] a, input logic [31:0] b,
	input logic [3:0] f);
	logic [31:0] x;
	logic [31:0] y;
	logic ci;
	logic [32:0] s;
	x = (o == 3'h6) ? 32'h0 : a;
	y = (o == 3'h6) ? ~a : ((o > 3'h2) ? ~b : b);
	ci = (o == 3'h2) ? f[1] : ((o == 3'h5) ? !f[1] : (o > 3'h2));
	s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
	if (o == 3'h0 || o == 3'h3)
		return {f, s[31:0]};
	return {s[31], s[31:0] == 32'h0, s[32], x[31] == y[31] && s[31] != x[31], s[31:0]};
endfunction
task automatic run(input logic [31:0] c, input logic [9:0] im, input logic lg);
	logic [31:0] a = pick($urandom % 5);
	logic [31:0] b = pick($urandom % 5);
	logic [31:0] o = $urandom;
	logic [3:0] f = 4'($urandom);
	logic [3:0] d = c[4] ? c[15:12] : c[11:8];
	logic [35:0] e;
	wr({26'h1, d, 2'h0}, o);
	wr({26'h1, c[19:16], 2'h0}, b);
	wr({26'h1, c[15:12], 2'h0}, a);
	b = (c[19:16] == c[15:12]) ? a : b;
	o = (d == c[15:12]) ? a : ((d == c[19:16]) ? b : o);
	wr(32'h8, {28'h0, f});
	wr(32'h4, {22'h0, im});
	wr(32'h0, c);
	e = calc(c[2:0], a, c[3] ? {22'h0, im} : b, f);
	rd(32'hC);
	chk(q, {30'h0, !lg, 1'b1});
	rd({26'h1, d, 2'h0});
	chk(q, lg ? e[31:0] : o);
	chk({28'h0, flags}, {28'h0, lg ? e[35:32] : f});
endtask
initial
begin
	void'($urandom(3227));
	repeat (6) @(posedge clk_i);
	rst_b_i <= 1'b1;
	@(posedge clk_i);
	rd(32'h8);
	chk(q, 32'h0);
	zero_chk;
	wr(32'h20, 32'hA5A5A5A5);
	rd(32'h20);
	chk(q, 32'h0);
	$display("test reset done");
	foreach (lim[k])
		run(lim[k][31:0], lim[k][41:32], lim[k][42]);
	$display("test limits done");
	for (int i = 0; i < 60; i++)
	begin
		op = 3'($urandom % 7);
		s1 = 4'($urandom % 8);
		dd = (op == 3'h2 || op == 3'h5) ? s1 : 4'($urandom % 8);
		run({12'h0, 4'($urandom % 8), s1, dd, 3'h0, 1'($urandom),
			(op == 3'h1 || op == 3'h4) && $urandom % 2, op},
			10'((dd == s1) ? $urandom % 256 : $urandom % 8), 1'b1);
	end
	$display("test random done");
	// Reset again in mid-run: results and registers must clear
	rst_b_i <= 1'b0;
	repeat (2) @(posedge clk_i);
	rst_b_i <= 1'b1;
	@(posedge clk_i);
	zero_chk;
	$display("test second reset done");
	test_done;
end
endmodule // test_add_subtract_flag_alu
`default_nettype wire
